// ===== verilog/dma_hs_defines.vh
// register offsets, field positions and the control reset value of the dma handshake block
`ifndef DMA_HS_DEFINES_VH
`define DMA_HS_DEFINES_VH

`define OFF_CTRL      12'h000
`define OFF_START     12'h004
`define OFF_COUNT     12'h008
`define OFF_STATUS    12'h00c
`define OFF_IRQ_STAT  12'h010
`define OFF_IRQ_MASK  12'h014
`define OFF_DONE_CNT  12'h018

// control register fields
`define CTRL_REQ_POL   0
`define CTRL_BUSY_POL  1
`define CTRL_BURST     2
`define CTRL_WORDHOST  3
`define CTRL_CYC_LO    4
`define CTRL_CYC_HI    5
`define CTRL_ATTENTION_LINE      6
`define CTRL_IEN       7
`define CTRL_WIDTH     8
`define CTRL_RESET     8'h00

// interrupt status fields
`define IRQ_DONE       0
`define IRQ_ATTENTION_LINE       1
`define IRQ_FUNC2      2
`define IRQ_WIDTH      3

`define COUNT_WIDTH    16
`define SYNC_WIDTH     3

`endif

// ===== verilog/sync_bits.v
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module sync_bits #(
   parameter WIDTH = 3
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stage1[i] <= 1'b0;
               stage2[i] <= 1'b0;
            end else begin
               stage1[i] <= async_in[i];
               stage2[i] <= stage1[i];
            end
         end
      end
   endgenerate

   assign sync_out = stage2;
endmodule // sync_bits

// ===== verilog/dma_host_cycle_handshake.v
// dma word handshake toward a host dma card, with apb registers
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "dma_hs_defines.vh"

// Operation
// (RULE1) one rising request per transferred word
// (RULE2) attention drive stops transfer, sets ready, interrupts
// (RULE3) function two high: set interrupt, terminate
// (RULE4) function two acts on level, not edge
// (RULE5) burst refused for word-only host variant
// (RULE6) request polarity select: B high, A low
// (RULE7) busy polarity select: A high, B low
// (RULE8) request only while busy inactive
// (RULE9) host interface armed before device starts
// (RULE10) host holds busy during its cycle
// (RULE11) transfers begin only while ready low
// (RULE12) single-cycle line low means burst
// (RULE13) two cycle-type lines select host cycle
// (RULE14) host inputs synchronised by two flops
// (RULE15) request released after each cycle end
module dma_host_cycle_handshake (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        busy_in,
   input  wire        ready_n_in,
   input  wire        host_function_line_two,
   output reg         cycle_request,
   output reg         attention_line,
   output reg         single_cycle,
   output reg         cycle_type_bit0,
   output reg         cycle_type_bit1,
   output reg         irq
);
   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_REQ  = 2'b01;
   localparam [1:0] ST_BUSY = 2'b10;
   localparam [1:0] ST_GAP  = 2'b11;

   reg  [`CTRL_WIDTH-1:0]  ctrl;
   reg  [`COUNT_WIDTH-1:0] word_count;
   reg  [`COUNT_WIDTH-1:0] done_count;
   reg  [`IRQ_WIDTH-1:0]   irq_stat;
   reg  [`IRQ_WIDTH-1:0]   irq_mask;
   reg  [1:0]              state;
   reg  [1:0]              next_state;
   reg                     active;
   reg                     dma_ready;
   reg                     req_level;
   reg  [31:0]             next_prdata;
   reg                     next_pslverr;
   wire [`SYNC_WIDTH-1:0]  sync_q;
   wire                    busy_raw;
   wire                    host_ready_n;
   wire                    func2;
   wire                    busy_act;
   wire                    attention_line_now;
   wire                    stop_now;
   wire                    acc;
   wire                    wr;
   wire                    rd;
   wire                    word_end;
   wire                    sel_ctrl;
   wire                    sel_start;
   wire                    sel_count;
   wire                    sel_status;
   wire                    sel_irq_stat;
   wire                    sel_irq_mask;
   wire                    sel_done_cnt;
   wire                    start_go;
   wire [`IRQ_WIDTH-1:0]   irq_clr;
   reg  [`IRQ_WIDTH-1:0]   ev;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   sync_bits #(
      .WIDTH    (`SYNC_WIDTH)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({host_function_line_two, ready_n_in, busy_in}),
      .sync_out (sync_q)
   ); // RULE14

   assign busy_raw     = sync_q[0];
   assign host_ready_n = sync_q[1];
   assign func2        = sync_q[2];
   // select A (0) busy active high, B (1) active low
   assign busy_act     = busy_raw ^ ctrl[`CTRL_BUSY_POL]; // RULE7

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   assign acc = psel & penable & ~pready;
   assign wr  = acc & pwrite;
   assign rd  = acc & ~pwrite;

   assign sel_ctrl     = (paddr == `OFF_CTRL);
   assign sel_start    = (paddr == `OFF_START);
   assign sel_count    = (paddr == `OFF_COUNT);
   assign sel_status   = (paddr == `OFF_STATUS);
   assign sel_irq_stat = (paddr == `OFF_IRQ_STAT);
   assign sel_irq_mask = (paddr == `OFF_IRQ_MASK);
   assign sel_done_cnt = (paddr == `OFF_DONE_CNT);

   assign attention_line_now = wr & sel_ctrl & pwdata[`CTRL_ATTENTION_LINE];
   assign stop_now = attention_line_now | func2; // RULE2 RULE3 RULE4
   // start refused with a zero count
   assign start_go = wr & sel_start & pwdata[0] & (word_count != 16'h0000);

   // ------------------------------------------------------------
   // handshake machine
   // ------------------------------------------------------------
   assign word_end = (state == ST_BUSY) & ~busy_act; // RULE10

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            // start needs host ready low and busy idle
            if (active & ~host_ready_n & ~busy_act) begin // RULE11 RULE8
               next_state = ST_REQ;
            end
         end
         ST_REQ: begin
            if (busy_act) begin
               next_state = ST_BUSY;
            end
         end
         ST_BUSY: begin
            if (~busy_act) begin
               next_state = ST_GAP; // RULE15
            end
         end
         ST_GAP: begin
            if (active & ~busy_act) begin
               next_state = ST_REQ; // RULE1 RULE8
            end else if (~active) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (stop_now) begin
         next_state = ST_IDLE;
      end
   end

   always @* begin
      ev = {`IRQ_WIDTH{1'b0}};
      ev[`IRQ_DONE]  = word_end & active & (word_count == 16'h0001);
      ev[`IRQ_ATTENTION_LINE]  = attention_line_now & ctrl[`CTRL_IEN]; // RULE2
      ev[`IRQ_FUNC2] = func2; // RULE3 RULE4
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= ST_IDLE;
         req_level <= 1'b0;
      end else begin
         state     <= next_state;
         req_level <= (next_state == ST_REQ);
      end
   end

   // ------------------------------------------------------------
   // word counting and transfer status
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active     <= 1'b0;
         dma_ready  <= 1'b1;
         word_count <= 16'h0000;
         done_count <= 16'h0000;
      end else begin
         if (stop_now) begin
            active    <= 1'b0;
            dma_ready <= 1'b1; // RULE2 RULE3
         end else if (start_go) begin
            active    <= 1'b1;
            dma_ready <= 1'b0;
         end else if (word_end & active) begin
            word_count <= word_count - 16'h0001;
            done_count <= done_count + 16'h0001;
            if (word_count == 16'h0001) begin
               active    <= 1'b0;
               dma_ready <= 1'b1;
            end
         end
         if (wr & sel_count & ~active) begin
            word_count <= pwdata[`COUNT_WIDTH-1:0];
            done_count <= 16'h0000;
         end
      end
   end

   // ------------------------------------------------------------
   // read mux and error decode
   // ------------------------------------------------------------
   always @* begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (pwrite) begin
         // status and done count are read-only
         next_pslverr = ~(sel_ctrl | sel_start | sel_count | sel_irq_stat | sel_irq_mask);
      end else begin
         next_pslverr = ~(sel_ctrl | sel_start | sel_count | sel_status | sel_irq_stat
                          | sel_irq_mask | sel_done_cnt);
         case (paddr)
            `OFF_CTRL:     next_prdata = {24'h000000, ctrl};
            `OFF_COUNT:    next_prdata = {16'h0000, word_count};
            `OFF_STATUS:   next_prdata = {26'h0000000, state, func2, host_ready_n,
                                          busy_act, dma_ready};
            `OFF_IRQ_STAT: next_prdata = {29'h00000000, irq_stat};
            `OFF_IRQ_MASK: next_prdata = {29'h00000000, irq_mask};
            `OFF_DONE_CNT: next_prdata = {16'h0000, done_count};
            default:       next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers and bus answer
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl     <= `CTRL_RESET;
         irq_mask <= {`IRQ_WIDTH{1'b0}};
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         prdata   <= 32'h0000_0000;
      end else begin
         pready  <= acc;
         pslverr <= acc & next_pslverr;
         prdata  <= rd ? next_prdata : 32'h0000_0000;
         if (wr & sel_ctrl) begin
            ctrl <= pwdata[`CTRL_WIDTH-1:0];
            // burst refused for the word-only host
            if (pwdata[`CTRL_WORDHOST]) begin
               ctrl[`CTRL_BURST] <= 1'b0; // RULE5
            end
            ctrl[`CTRL_ATTENTION_LINE] <= 1'b0;
         end
         if (wr & sel_irq_mask) begin
            irq_mask <= pwdata[`IRQ_WIDTH-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // sticky interrupt status, one flop per event
   // ------------------------------------------------------------
   assign irq_clr = (wr & sel_irq_stat) ? pwdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

   genvar b;
   generate
      for (b = 0; b < `IRQ_WIDTH; b = b + 1) begin : g_irq
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               irq_stat[b] <= 1'b0;
            end else if (ev[b]) begin
               // set wins over write-one clear
               irq_stat[b] <= 1'b1;
            end else if (irq_clr[b]) begin
               irq_stat[b] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // host-side outputs
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cycle_request   <= 1'b0;
         attention_line  <= 1'b0;
         single_cycle    <= 1'b1;
         cycle_type_bit0 <= 1'b0;
         cycle_type_bit1 <= 1'b0;
         irq             <= 1'b0;
      end else begin
         // select B (1) active high, A (0) active low
         cycle_request   <= req_level ^ ~ctrl[`CTRL_REQ_POL]; // RULE6 RULE1
         attention_line  <= attention_line_now; // RULE2
         single_cycle    <= ~(ctrl[`CTRL_BURST] & ~ctrl[`CTRL_WORDHOST]); // RULE12 RULE5
         cycle_type_bit0 <= ctrl[`CTRL_CYC_LO]; // RULE13
         cycle_type_bit1 <= ctrl[`CTRL_CYC_HI]; // RULE13
         irq             <= |(irq_stat & irq_mask);
      end
   end
endmodule // dma_host_cycle_handshake

// ===== verification/dma_hs_props.sv
// port assertions of the dma host cycle handshake
`timescale 1ns/1ps
module dma_hs_props (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        busy_in,
   input wire        ready_n_in,
   input wire        host_function_line_two,
   input wire        cycle_request,
   input wire        attention_line,
   input wire        single_cycle,
   input wire        cycle_type_bit0,
   input wire        cycle_type_bit1,
   input wire        irq
);
   // ----
   // shadow of control and mask
   // ----
   reg  [7:0] ctrl, mk;
   reg  [2:0] pc;
   wire       wr = psel & penable & pwrite & ~pready;
   wire       cw = wr && paddr == 12'h000;
   wire       aw = cw && pwdata[6];
   wire       q  = pc == 3'h7;
   wire       ra = cycle_request == ctrl[0];
   wire       ba = busy_in ^ ctrl[1];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 8'h00;
         mk <= 8'h00;
         pc <= 3'h0;
      end else begin
         pc <= cw ? 3'h0 : pc + {2'b00, ~q};
         if (cw) ctrl <= pwdata[7:0];
         if (wr && paddr == 12'h014) mk <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_busy_up;
      q && ra && $rose(ba);
   endsequence
   a_req_busy_idle: assert property ($rose(ra) && q |-> !ba && !$past(ba))
      else $error("request raised while busy active");
   a_req_ready_low: assert property ($rose(ra) && q |-> !$past(ready_n_in, 4))
      else $error("request raised while ready high");
   a_sync_two_flops: assert property (s_busy_up |=> ra [*2])
      else $error("busy acted on before synchronising");
   a_req_drops: assert property (s_busy_up |-> ##[2:6] !ra)
      else $error("request not released after busy");
   a_func2_stop: assert property (host_function_line_two [*6] |-> !ra)
      else $error("request active while function two high");
   a_func2_irq: assert property (host_function_line_two [*6] && mk[2] |-> irq)
      else $error("no interrupt while function two high");
   a_attention_line_pulse: assert property (aw |=> attention_line ##1 !attention_line)
      else $error("attention pulse missing");
   a_attention_line_cause: assert property ($rose(attention_line) |-> $past(aw))
      else $error("attention without control write");
   a_attention_line_stop: assert property (attention_line |-> ##[0:2] !ra [*3])
      else $error("transfer not stopped by attention");
   a_cycle_type: assert property (q |-> {cycle_type_bit1, cycle_type_bit0} == ctrl[5:4])
      else $error("cycle type lines wrong");
   a_burst_line: assert property (q |-> single_cycle == !(ctrl[2] && !ctrl[3]))
      else $error("single cycle line wrong");
endmodule // dma_hs_props

bind dma_host_cycle_handshake dma_hs_props u_dma_hs_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .busy_in, .ready_n_in, .host_function_line_two,
   .cycle_request, .attention_line, .single_cycle, .cycle_type_bit0, .cycle_type_bit1, .irq);

// ===== verification/host_dma_model.sv
// host dma card model: busy and ready lines
`timescale 1ns/1ps
module host_dma_model (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       cycle_request,
   input  wire       req_pol,
   input  wire       busy_pol,
   input  wire       armed,
   input  wire [3:0] dly,
   output wire       busy_in,
   output wire       ready_n_in,
   output reg  [7:0] words
);
   reg       act;
   reg [3:0] cnt;
   wire      req_on = cycle_request == req_pol;
   assign busy_in    = act ^ busy_pol;
   assign ready_n_in = ~armed;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act <= 1'b0;
         cnt <= 4'h0;
         words <= 8'h00;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else if (!act && req_on && armed) begin
         act <= 1'b1;
         cnt <= dly;
      end else if (act && !req_on) begin
         act <= 1'b0;
         cnt <= dly;
         words <= words + 8'h01;
      end
   end
endmodule // host_dma_model

// ===== verification/dma_host_cycle_handshake_tb.sv
// testbench of the dma host cycle handshake
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module dma_host_cycle_handshake_tb;
   reg         pclk, presetn, psel, penable, pwrite, f2, rp, bp, arm, er;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [7:0]  w0;
   reg  [3:0]  dly;
   wire [31:0] prdata;
   wire [7:0]  words;
   wire        pready, pslverr, busy_in, ready_n_in, cycle_request, attention_line;
   wire        single_cycle, cycle_type_bit0, cycle_type_bit1, irq;
   integer     fails, num_checks, i, n;
   dma_host_cycle_handshake u_dma_host_cycle_handshake (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .busy_in, .ready_n_in,
      .host_function_line_two(f2), .cycle_request, .attention_line, .single_cycle,
      .cycle_type_bit0, .cycle_type_bit1, .irq);
   host_dma_model u_host_dma_model (.pclk, .presetn, .cycle_request, .req_pol(rp),
      .busy_pol(bp), .armed(arm), .dly, .busy_in, .ready_n_in, .words);
   initial begin
      pclk = 0;
      forever #4 pclk = ~pclk;
   end
   // ----
   // apb master and verdict
   // ----
   task xfer(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
         @(posedge pclk);
         penable <= 1;
         n = 0;
         do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
         if (n == 20) fails++;
         rd = prdata;
         er = pslverr;
         psel <= 0; penable <= 0;
      end
   endtask
   task print_verdict;
      begin
         if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      #200000;
      fails++;
      print_verdict;
   end
   initial begin
      fails = 0; num_checks = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 0; pwdata = 0; f2 = 0; rp = 0; bp = 0; arm = 0; dly = 1;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      xfer(0, 12'h000, 0); `CHK(rd, 32'h0)
      xfer(0, 12'h01c, 0); `CHK(er, 1'b1)
      xfer(1, 12'h014, 7);
      // each polarity option: slow start until armed, then three words
      for (i = 0; i < 4; i++) begin
         xfer(1, 12'h000, i);
         rp <= i[0]; bp <= i[1]; dly <= {i[1:0], 2'b01};
         w0 = words;
         xfer(1, 12'h008, 3);
         xfer(1, 12'h004, 1);
         repeat (20) @(posedge pclk);
         `CHK(cycle_request, ~rp)
         arm <= 1;
         n = 0;
         while (irq !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
         `CHK(irq, 1'b1)
         `CHK(words, w0 + 8'd3)
         xfer(0, 12'h010, 0); `CHK(rd, 32'h1)
         xfer(0, 12'h018, 0); `CHK(rd, 32'h3)
         xfer(1, 12'h010, 1);
         @(posedge pclk);
         `CHK(irq, 1'b0)
         `CHK(cycle_request, ~rp)
         arm <= 0;
      end
      rp <= 0; bp <= 0;
      for (i = 0; i < 16; i++) begin
         xfer(1, 12'h000, i << 2);
         repeat (2) @(posedge pclk);
         `CHK({cycle_type_bit1, cycle_type_bit0}, i[3:2])
         `CHK(single_cycle, !(i[0] && !i[1]))
         xfer(0, 12'h000, 0); `CHK(rd[2], i[0] && !i[1])
      end
      xfer(1, 12'h000, 8'h80);
      repeat (4) @(posedge pclk);
      arm <= 1;
      xfer(1, 12'h008, 16'h00ff);
      xfer(1, 12'h004, 1);
      repeat (30) @(posedge pclk);
      f2 <= 1;
      repeat (8) @(posedge pclk);
      `CHK(cycle_request, 1'b1)
      xfer(0, 12'h00c, 0); `CHK(rd[3], 1'b1)
      xfer(1, 12'h010, 7);
      xfer(0, 12'h010, 0); `CHK(rd[2], 1'b1)
      f2 <= 0;
      repeat (6) @(posedge pclk);
      xfer(1, 12'h010, 7);
      @(posedge pclk);
      `CHK(irq, 1'b0)
      `CHK(cycle_request, 1'b1)
      xfer(1, 12'h008, 16'h00ff);
      xfer(1, 12'h004, 1);
      repeat (30) @(posedge pclk);
      xfer(1, 12'h000, 8'hc0);
      repeat (4) @(posedge pclk);
      `CHK(cycle_request, 1'b1)
      xfer(0, 12'h00c, 0); `CHK(rd[0], 1'b1)
      xfer(0, 12'h010, 0); `CHK(rd[1], 1'b1)
      `CHK(irq, 1'b1)
      xfer(1, 12'h014, 0);
      @(posedge pclk);
      `CHK(irq, 1'b0)
      print_verdict;
   end
endmodule // dma_host_cycle_handshake_tb
